// *** rtl/cbs_pkg.sv ***
// Purpose: Shared types and constants of the bus cycle sequencer.
// Assumes: One bus clock; all pins sampled on its rising edge.
// Notes:   No timing constants; the sequencer counts ready beats only.

package cbs_pkg;

    // ************************************************************
    // Bus states, one per clock period
    // ************************************************************
    typedef enum logic [2:0]
    {
        BUS_IDLE_STATE,
        ADDR_PHASE_STATE,
        DATA_PHASE_STATE,
        PIPE_FIRST_STATE,
        PIPE_OVERLAP_STATE,
        TURNAROUND_STATE
    } cbs_state_e;

    // ************************************************************
    // Widths and counts
    // ************************************************************
    localparam int         ADDR_W      = 29;     // Quad-word address
    localparam int         DATA_W      = 64;     // Data bus width
    localparam int         BEAT_W      = 2;      // Beat counter width
    localparam logic [1:0] BURST_LAST  = 2'h3;   // Fourth beat of a burst
    localparam logic [1:0] SINGLE_LAST = 2'h0;   // Only beat of a single
    localparam logic [1:0] BEAT_RST    = 2'h0;   // Counter reset value
    localparam logic       PIN_OFF     = 1'h1;   // Idle level, low-true pins
    localparam logic       FLAG_RST    = 1'h0;   // Reset value of flags

endpackage : cbs_pkg

// *** rtl/cbs_req_latch.sv ***
// Purpose: One-entry holding slot for the next bus cycle request.
// Assumes: Core holds its request stable until reqReady is seen.
// Notes:   Slot is freed only when the sequencer takes the entry.

`timescale 1ns/1ns

module cbs_req_latch
(
    input  wire logic                      mclk,
    input  wire logic                      rst_n,
    input  wire logic                      ce,
    input  wire logic                      reqValid,
    input  wire logic                      reqWrite,
    input  wire logic                      reqBurst,
    input  wire logic [cbs_pkg::ADDR_W-1:0] reqAddr,
    input  wire logic                      pop,
    output logic                           reqReady,
    output logic                           pendValid,
    output logic                           pendWrite,
    output logic                           pendBurst,
    output logic [cbs_pkg::ADDR_W-1:0]      pendAddr
);

    logic take;   // Request accepted this clock

    // Accept while empty or while the entry leaves this clock
    assign reqReady = ce && (!pendValid || pop);
    assign take     = reqValid && reqReady;

    // ************************************************************
    // Slot storage
    // ************************************************************
    // Valid flag; a new take wins over the pop
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
            pendValid <= cbs_pkg::FLAG_RST;
        else if (ce)
            pendValid <= take || (pendValid && !pop);
    end

    // Cycle definition held with the flag
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            pendWrite <= cbs_pkg::FLAG_RST;
            pendBurst <= cbs_pkg::FLAG_RST;
            pendAddr  <= '0;
        end
        else if (ce && take)
        begin
            pendWrite <= reqWrite;
            pendBurst <= reqBurst;
            pendAddr  <= reqAddr;
        end
    end

    a_slot_hold : assert property (@(posedge mclk) disable iff (!rst_n)
        pendValid && !pop |=> pendValid && $stable(pendAddr))
        else $error("pending entry lost");

endmodule : cbs_req_latch

// *** rtl/cbs_beat_counter.sv ***
// Purpose: Counts ready beats of the current cycle, flags the last.
// Assumes: clear and beat never both matter; clear wins.
// Notes:   Single cycles end on one beat, bursts on four.

`timescale 1ns/1ns

module cbs_beat_counter
(
    input  wire logic mclk,
    input  wire logic rst_n,
    input  wire logic ce,
    input  wire logic clear,
    input  wire logic beat,
    input  wire logic burst,
    output logic      lastBeat
);

    logic [cbs_pkg::BEAT_W-1:0] countQ;   // Beats already taken

    // Final beat decode depends on cycle kind
    assign lastBeat = beat &&
        (countQ == (burst ? cbs_pkg::BURST_LAST : cbs_pkg::SINGLE_LAST));

    // ************************************************************
    // Beat count
    // ************************************************************
    // Waits leave the count alone, so wait states cost nothing
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
            countQ <= cbs_pkg::BEAT_RST;
        else if (ce && clear)
            countQ <= cbs_pkg::BEAT_RST;
        else if (ce && beat)
            countQ <= countQ + 2'h1;
    end

    a_single_one : assert property (@(posedge mclk) disable iff (!rst_n)
        beat && !burst && countQ == cbs_pkg::BEAT_RST |-> lastBeat)
        else $error("single cycle not ended on first ready");

endmodule : cbs_beat_counter

// *** rtl/cbs_bus_seq.sv ***
// Purpose: Processor-side bus cycle sequencer for single and burst
//          cycles, non-pipelined and two-deep pipelined.
// Assumes: Pins are synchronous to mclk; the core keeps wrData valid
//          for the next beat to load until wrBeatTaken.
// Notes:   Back-off aborts the current cycle and reruns it from idle.

`timescale 1ns/1ns

// Overview of operation
// - Exactly one of six states each clock.
// - Reset, back-off force idle; idle during hold.
// - First clock strobes address and definition.
// - Data clocks move data and sample ready.
// - Lone former pipelined cycle ends in data clocks.
// - Pipe first clock: data plus next strobe.
// - Overlap keeps data going, next address held.
// - One turnaround clock on direction change.
// - Idle until new or aborted cycle pending.
// - First clock goes to data clocks unless backed off.
// - Wait in data clocks unless pipelining.
// - Last ready, pending, no hit: first clock.
// - Last ready, nothing pending or hit: idle.
// - Pending and next-address asserted: pipe first.
// - Pipe last ready: turnaround or data; else overlap.
// - After turnaround: pipe first or data clocks.
// - Non-pipelined allows one outstanding cycle only.
// - Missing ready means wait state, resample.
module cbs_bus_seq
(
    input  wire logic                       mclk,
    input  wire logic                       rst_n,
    input  wire logic                       ce,
    input  wire logic                       reqValid,
    output logic                            reqReady,
    input  wire logic                       reqWrite,
    input  wire logic                       reqBurst,
    input  wire logic [cbs_pkg::ADDR_W-1:0] reqAddr,
    input  wire logic [cbs_pkg::DATA_W-1:0] wrData,
    output logic                            wrBeatTaken,
    output logic [cbs_pkg::DATA_W-1:0]      rdData,
    output logic                            rdValid,
    input  wire logic                       snoopHit,
    input  wire logic                       holdReq,
    output logic                            holdAck,
    output logic [cbs_pkg::ADDR_W-1:0]      addrOut,
    output logic                            writeOut,
    output logic                            burstOut,
    output logic                            addressStrobeN,
    input  wire logic                       burstReadyN,
    input  wire logic                       nextAddressN,
    input  wire logic                       backoffN,
    output logic                            snoopHitModifiedN,
    input  wire logic [cbs_pkg::DATA_W-1:0] dataIn,
    output logic [cbs_pkg::DATA_W-1:0]      dataOut,
    output logic                            dataOe,
    output cbs_pkg::cbs_state_e             busState
);

    // ************************************************************
    // Helpers
    // ************************************************************
    // States in which data moves and ready is sampled
    function automatic logic isDataState(input cbs_pkg::cbs_state_e s);
        isDataState = (s == cbs_pkg::DATA_PHASE_STATE) ||
                      (s == cbs_pkg::PIPE_FIRST_STATE) ||
                      (s == cbs_pkg::PIPE_OVERLAP_STATE);
    endfunction : isDataState

    // Data bus reverses between the two cycles
    function automatic logic deadNeeded(input logic curW, input logic nxtW);
        deadNeeded = curW != nxtW;
    endfunction : deadNeeded

    // ************************************************************
    // Declarations
    // ************************************************************
    cbs_pkg::cbs_state_e             stateQ;      // Present bus state
    cbs_pkg::cbs_state_e             stateD;      // Next bus state
    logic                            pendValid;   // New cycle waiting
    logic                            pendWrite;   // Its direction
    logic                            pendBurst;   // Its kind
    logic [cbs_pkg::ADDR_W-1:0]      pendAddr;    // Its address
    logic                            curWriteQ;   // Current cycle direction
    logic                            curBurstQ;   // Current cycle kind
    logic [cbs_pkg::ADDR_W-1:0]      curAddrQ;    // Current cycle address
    logic                            abortedQ;    // Current cycle to rerun
    logic                            beat;        // Ready seen in data clock
    logic                            lastRdy;     // Final ready of cycle
    logic                            retry;       // Rerun of aborted cycle
    logic                            pop;         // Take the waiting cycle
    logic                            pipeLast;    // Cycle ahead of the pipelined one ends

    // ************************************************************
    // Sub-blocks
    // ************************************************************
    // Waiting cycle; a strobed pipelined cycle stays here until it
    // becomes current, so back-off never loses it
    cbs_req_latch u_latch
    (
        .mclk      (mclk),
        .rst_n     (rst_n),
        .ce        (ce),
        .reqValid  (reqValid),
        .reqWrite  (reqWrite),
        .reqBurst  (reqBurst),
        .reqAddr   (reqAddr),
        .pop       (pop),
        .reqReady  (reqReady),
        .pendValid (pendValid),
        .pendWrite (pendWrite),
        .pendBurst (pendBurst),
        .pendAddr  (pendAddr)
    );

    // Counts ready beats of the current cycle
    cbs_beat_counter u_beats
    (
        .mclk     (mclk),
        .rst_n    (rst_n),
        .ce       (ce),
        .clear    (pop || retry),
        .beat     (beat),
        .burst    (curBurstQ),
        .lastBeat (lastRdy)
    );

    // Ready only counts in a data-moving clock
    assign beat        = !burstReadyN && isDataState(stateQ);
    assign wrBeatTaken = ce && isDataState(stateD) && (pop ? pendWrite : curWriteQ) && (!dataOe || beat);
    assign busState    = stateQ;

    // ************************************************************
    // Next-state logic
    // ************************************************************
    always_comb
    begin
        stateD = stateQ;
        unique case (stateQ)
            cbs_pkg::BUS_IDLE_STATE:
                // Hold request keeps the bus parked
                if ((pendValid || abortedQ) && !holdReq && !holdAck)
                    stateD = cbs_pkg::ADDR_PHASE_STATE;
            cbs_pkg::ADDR_PHASE_STATE:
                stateD = cbs_pkg::DATA_PHASE_STATE;
            cbs_pkg::DATA_PHASE_STATE:
                if (lastRdy)
                begin
                    // Modified-line hit leaves room for the write-back
                    if (pendValid && snoopHitModifiedN)
                        stateD = cbs_pkg::ADDR_PHASE_STATE;
                    else
                        stateD = cbs_pkg::BUS_IDLE_STATE;
                end
                else if (pendValid && !nextAddressN)
                    stateD = cbs_pkg::PIPE_FIRST_STATE;
                else
                    stateD = cbs_pkg::DATA_PHASE_STATE;
            cbs_pkg::PIPE_FIRST_STATE,
            cbs_pkg::PIPE_OVERLAP_STATE:
                if (lastRdy)
                    stateD = deadNeeded(curWriteQ, pendWrite) ?
                             cbs_pkg::TURNAROUND_STATE :
                             cbs_pkg::DATA_PHASE_STATE;
                else
                    stateD = cbs_pkg::PIPE_OVERLAP_STATE;
            cbs_pkg::TURNAROUND_STATE:
                if (pendValid && !nextAddressN)
                    stateD = cbs_pkg::PIPE_FIRST_STATE;
                else
                    stateD = cbs_pkg::DATA_PHASE_STATE;
            default:
                stateD = cbs_pkg::BUS_IDLE_STATE;
        endcase
        // Back-off overrides every other choice
        if (!backoffN)
            stateD = cbs_pkg::BUS_IDLE_STATE;
    end

    // Cycle hand-over decodes
    assign retry    = ce && stateQ == cbs_pkg::BUS_IDLE_STATE &&
                      stateD == cbs_pkg::ADDR_PHASE_STATE && abortedQ;
    assign pipeLast = backoffN && lastRdy &&
                      (stateQ == cbs_pkg::PIPE_FIRST_STATE ||
                       stateQ == cbs_pkg::PIPE_OVERLAP_STATE);
    assign pop      = ce && (pipeLast ||
                      (stateD == cbs_pkg::ADDR_PHASE_STATE && !abortedQ));

    // ************************************************************
    // State register
    // ************************************************************
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
            stateQ <= cbs_pkg::BUS_IDLE_STATE;
        else if (ce)
            stateQ <= stateD;
    end

    // ************************************************************
    // Current cycle bookkeeping
    // ************************************************************
    // Definition of the cycle whose data is moving
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            curWriteQ <= cbs_pkg::FLAG_RST;
            curBurstQ <= cbs_pkg::FLAG_RST;
            curAddrQ  <= '0;
        end
        else if (pop)
        begin
            curWriteQ <= pendWrite;
            curBurstQ <= pendBurst;
            curAddrQ  <= pendAddr;
        end
    end

    // Aborted cycle is rerun whole; set wins over the rerun clear
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
            abortedQ <= cbs_pkg::FLAG_RST;
        else if (ce && !backoffN && stateQ != cbs_pkg::BUS_IDLE_STATE)
            abortedQ <= 1'h1;
        else if (retry)
            abortedQ <= cbs_pkg::FLAG_RST;
    end

    // ************************************************************
    // Address and definition pins
    // ************************************************************
    // Strobe in first clock and in pipe first clock only
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
            addressStrobeN <= cbs_pkg::PIN_OFF;
        else if (ce)
            addressStrobeN <= !(stateD == cbs_pkg::ADDR_PHASE_STATE ||
                                stateD == cbs_pkg::PIPE_FIRST_STATE);
    end

    // Address follows the strobed cycle and then holds
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            addrOut  <= '0;
            writeOut <= cbs_pkg::FLAG_RST;
            burstOut <= cbs_pkg::FLAG_RST;
        end
        else if (ce && stateD == cbs_pkg::ADDR_PHASE_STATE)
        begin
            addrOut  <= abortedQ ? curAddrQ : pendAddr;
            writeOut <= abortedQ ? curWriteQ : pendWrite;
            burstOut <= abortedQ ? curBurstQ : pendBurst;
        end
        else if (ce && stateD == cbs_pkg::PIPE_FIRST_STATE)
        begin
            addrOut  <= pendAddr;
            writeOut <= pendWrite;
            burstOut <= pendBurst;
        end
    end

    // ************************************************************
    // Data bus
    // ************************************************************
    // Drive write data through every data clock and its waits
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            dataOe  <= cbs_pkg::FLAG_RST;
            dataOut <= '0;
        end
        else if (ce)
        begin
            dataOe  <= isDataState(stateD) &&
                       (pop ? pendWrite : curWriteQ);
            dataOut <= wrBeatTaken ? wrData : dataOut;
        end
    end

    // Capture read data on each ready of a read
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            rdValid <= cbs_pkg::FLAG_RST;
            rdData  <= '0;
        end
        else if (ce)
        begin
            rdValid <= beat && !curWriteQ;
            if (beat && !curWriteQ)
                rdData <= dataIn;
        end
    end

    // ************************************************************
    // Snoop and hold
    // ************************************************************
    // Hit-modified pin is registered from the cache
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
            snoopHitModifiedN <= cbs_pkg::PIN_OFF;
        else if (ce)
            snoopHitModifiedN <= !snoopHit;
    end

    // Acknowledge only once the bus has gone idle
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
            holdAck <= cbs_pkg::FLAG_RST;
        else if (ce)
            holdAck <= holdReq && stateD == cbs_pkg::BUS_IDLE_STATE;
    end

    // ************************************************************
    // Checks
    // ************************************************************
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    a_state_legal : assert property (
        stateQ inside {cbs_pkg::BUS_IDLE_STATE, cbs_pkg::ADDR_PHASE_STATE,
                       cbs_pkg::DATA_PHASE_STATE, cbs_pkg::PIPE_FIRST_STATE,
                       cbs_pkg::PIPE_OVERLAP_STATE, cbs_pkg::TURNAROUND_STATE})
        else $error("illegal bus state");
    a_backoff_idle : assert property (ce && !backoffN |=>
        stateQ == cbs_pkg::BUS_IDLE_STATE && addressStrobeN)
        else $error("back-off did not idle the bus");
    a_hold_idle : assert property (holdAck |->
        stateQ == cbs_pkg::BUS_IDLE_STATE)
        else $error("bus active during hold acknowledge");
    a_strobe_first : assert property (
        stateQ == cbs_pkg::ADDR_PHASE_STATE |-> !addressStrobeN)
        else $error("no strobe in first clock");
    a_first_data : assert property (ce && backoffN &&
        stateQ == cbs_pkg::ADDR_PHASE_STATE |=>
        stateQ == cbs_pkg::DATA_PHASE_STATE ##0 addressStrobeN)
        else $error("first clock not followed by data clock");
    a_data_wait : assert property (ce && backoffN && !lastRdy &&
        stateQ == cbs_pkg::DATA_PHASE_STATE && (!pendValid || nextAddressN)
        |=> stateQ == cbs_pkg::DATA_PHASE_STATE)
        else $error("left data clocks without cause");
    a_pipe_enter : assert property (ce && backoffN && !lastRdy &&
        stateQ == cbs_pkg::DATA_PHASE_STATE && pendValid && !nextAddressN
        |=> stateQ == cbs_pkg::PIPE_FIRST_STATE && !addressStrobeN
        && addrOut == $past(pendAddr))
        else $error("pipelined cycle not strobed");
    a_last_idle : assert property (ce && backoffN && lastRdy &&
        stateQ == cbs_pkg::DATA_PHASE_STATE && (!pendValid || !snoopHitModifiedN)
        |=> stateQ == cbs_pkg::BUS_IDLE_STATE)
        else $error("did not idle after last ready");
    a_dead_once : assert property (ce &&
        stateQ == cbs_pkg::TURNAROUND_STATE |-> !dataOe ##1
        stateQ != cbs_pkg::TURNAROUND_STATE)
        else $error("turnaround not exactly one clock");

    c_burst_done : cover property (lastRdy && curBurstQ);
    c_pipe_run   : cover property (stateQ == cbs_pkg::PIPE_OVERLAP_STATE);
    c_turnaround : cover property (stateQ == cbs_pkg::TURNAROUND_STATE);
    c_backoff    : cover property (abortedQ ##1 retry);

endmodule : cbs_bus_seq

// *** dv/cbs_sys_model.sv ***
// Purpose: System logic model facing the bus sequencer.
// Assumes: Cycles end in strobe order; reset or back-off drops them.
// Notes:   Read data carries address and beat, so it can be predicted.
`timescale 1ns/1ns
module cbs_sys_model
(
    input  wire logic                       mclk,
    input  wire logic                       rst_n,
    input  wire logic                       naEn,
    input  wire logic [1:0]                 slow,
    input  wire cbs_pkg::cbs_state_e        busState,
    input  wire logic                       addressStrobeN,
    input  wire logic [cbs_pkg::ADDR_W-1:0] addrOut,
    input  wire logic                       burstOut,
    input  wire logic                       backoffN,
    output logic                            burstReadyN,
    output logic                            nextAddressN,
    output logic [cbs_pkg::DATA_W-1:0]      dataIn
);
    // ****************************
    // Outstanding cycles
    // ****************************
    logic [29:0] cyc[$];        // Burst flag and address per strobe
    int          beat = 0;      // Beats done on the head cycle
    int          waits = 0;     // Wait states spent on this beat
    logic        inData = 1'h0; // A data state runs this clock

    initial {burstReadyN, nextAddressN, dataIn} = '1;

    // Count beats at the edge, then answer once the new state is out
    always @(posedge mclk)
    begin
        if (!rst_n || !backoffN)
        begin
            cyc.delete();
            beat = 0;
        end
        else
        begin
            if (!addressStrobeN)
                cyc.push_back({burstOut, addrOut});
            waits = burstReadyN && inData ? waits + 1 : 0;
            beat += !burstReadyN;
            if (!burstReadyN && beat == (cyc[0][29] ? 4 : 1))
            begin
                void'(cyc.pop_front());
                beat = 0;
            end
        end
        #1;
        inData = busState inside {cbs_pkg::DATA_PHASE_STATE, cbs_pkg::PIPE_FIRST_STATE, cbs_pkg::PIPE_OVERLAP_STATE};
        burstReadyN = !(inData && cyc.size() > 0 && waits >= slow);
        nextAddressN = !naEn;
        // A released bus shows the inverse, never stale data
        dataIn = burstReadyN ? ~dataIn : {27'h0, cyc[0][28:0], 6'h0, 2'(beat)};
    end
endmodule : cbs_sys_model

// *** dv/cbs_bus_seq_tb_top.sv ***
// Purpose: Self-checking bench for the bus cycle sequencer.
// Assumes: The partner model answers every strobed cycle.
// Notes:   Write data is checked beat by beat at the pins.
`timescale 1ns/1ns
module cbs_bus_seq_tb_top;
    // ****************************
    // Pins and scoreboard
    // ****************************
    logic mclk, rst_n, reqValid, reqWrite, reqBurst, snoopHit, holdReq, backoffN, naEn, reqReady, wrBeatTaken;
    logic rdValid, holdAck, writeOut, burstOut, dataOe, addressStrobeN, burstReadyN, nextAddressN, hitN;
    logic tookQ, prevBoff, prevTd, prevNa, prevHit;
    logic [1:0] slow;
    logic [cbs_pkg::ADDR_W-1:0] reqAddr, addrOut;
    logic [63:0] wrData, rdData, dataIn, dataOut, addrQ[$], rdQ[$], wrQ[$]; // Expected strobes, read, write beats
    cbs_pkg::cbs_state_e busState, prevSt;
    int mismatches = 0, samples_checked = 0, strobes = 0, gap = 0, lastGap = 0, tdSeen = 0, seed = 32'hdde9;

    cbs_bus_seq cbs_bus_seq_i
    (
        .mclk, .rst_n, .ce(1'h1), .reqValid, .reqReady, .reqWrite, .reqBurst, .reqAddr, .wrData, .wrBeatTaken,
        .rdData, .rdValid, .snoopHit, .holdReq, .holdAck, .addrOut, .writeOut, .burstOut, .addressStrobeN,
        .burstReadyN, .nextAddressN, .backoffN, .snoopHitModifiedN(hitN), .dataIn, .dataOut, .dataOe, .busState
    );
    cbs_sys_model cbs_sys_model_i
    (
        .mclk, .rst_n, .naEn, .slow, .busState, .addressStrobeN, .addrOut, .burstOut, .backoffN,
        .burstReadyN, .nextAddressN, .dataIn
    );

    initial
    begin
        mclk = 1'h0;
        forever #50 mclk = ~mclk;
    end

    task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic results;
        $display("checked %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : results

    // One core request, held until the slot takes it; notes go first
    task automatic req(input logic w, input logic b, input logic [cbs_pkg::ADDR_W-1:0] a);
        @(negedge mclk);
        {reqValid, reqWrite, reqBurst, reqAddr} = {1'h1, w, b, a};
        addrQ.push_back({w, b, a});
        for (int n = 0; n < (b ? 4 : 1) && !w; n++)
            rdQ.push_back({27'h0, a, 6'h0, 2'(n)});
        while (!reqReady)
            @(negedge mclk);
        @(negedge mclk);
        reqValid = 1'h0;
    endtask : req

    // Bounded wait until the bus is parked and every strobe and read note is used
    task automatic waitIdle;
        for (int n = 0; n < 300 && (busState !== cbs_pkg::BUS_IDLE_STATE || addrQ.size() || rdQ.size()); n++)
            @(negedge mclk);
    endtask : waitIdle

    // Core notes the word the pins took, then presents the next one
    always @(negedge mclk)
        if (tookQ)
        begin
            wrQ.push_back(wrData);
            wrData <= {$random(seed), $random(seed)};
        end

    // Watcher: takes the oldest note whenever a result shows
    always @(posedge mclk)
    begin
        if (rst_n)
        begin
            if (!addressStrobeN)
            begin
                strobes++;
                lastGap = gap;
                gap = 0;
                check("strobe", {writeOut, burstOut, addrOut}, addrQ.pop_front());
                check("strobeSt", busState, busState == cbs_pkg::PIPE_FIRST_STATE && !prevNa ? busState : cbs_pkg::ADDR_PHASE_STATE);
            end
            gap += busState == cbs_pkg::BUS_IDLE_STATE;
            if (rdValid)
                check("rdData", rdData, rdQ.pop_front());
            if (!burstReadyN && dataOe)
                check("wrData", dataOut, wrQ.pop_front());
            check("hitPin", hitN, !prevHit);
            if (busState == cbs_pkg::TURNAROUND_STATE)
                check("tdOnce", {prevTd, dataOe}, 0);
            if (prevSt == cbs_pkg::ADDR_PHASE_STATE && prevBoff)
                check("afterAddr", busState, cbs_pkg::DATA_PHASE_STATE);
            if (!prevBoff || holdAck)
                check("idle", busState, cbs_pkg::BUS_IDLE_STATE);
        end
        tdSeen += busState == cbs_pkg::TURNAROUND_STATE;
        prevTd = busState == cbs_pkg::TURNAROUND_STATE;
        {prevSt, prevBoff, prevNa, tookQ, prevHit} = {busState, backoffN, nextAddressN, wrBeatTaken, snoopHit};
    end

    initial
    begin
        logic [31:0] rnd;
        {rst_n, reqValid, reqWrite, reqBurst, snoopHit, holdReq, naEn, slow, reqAddr, wrData} = '0;
        backoffN = 1'h1;
        repeat (12) @(negedge mclk);
        rst_n = 1'h1;
        // Plain cycles, then pipelined bursts of changing direction, then snoop hits
        for (int i = 0; i < 48; i++)
        begin
            rnd = $random(seed);
            {naEn, snoopHit, slow} = {i >= 16 && i < 32, i >= 40, rnd[1:0]};
            if (naEn)
                req(i[0], 1'h1, rnd[31:3]);
            else
                req(rnd[2], rnd[3], rnd[31:3]);
        end
        waitIdle();
        check("hitGap", lastGap > 0, 1);
        check("tdSeen", tdSeen > 0, 1);
        // Back-off in the first clock: the same cycle strobes again
        snoopHit = 1'h0;
        req(1'h0, 1'h0, 29'h1234567);
        addrQ.push_back({2'h0, 29'h1234567});
        for (int n = 0; n < 20 && busState !== cbs_pkg::ADDR_PHASE_STATE; n++)
            @(negedge mclk);
        backoffN = 1'h0;
        @(negedge mclk);
        backoffN = 1'h1;
        waitIdle();
        // Hold parks the bus; a waiting cycle must not strobe
        holdReq = 1'h1;
        for (int n = 0; n < 20 && holdAck !== 1'h1; n++)
            @(negedge mclk);
        check("holdAck", holdAck, 1);
        rnd = strobes;
        req(1'h1, 1'h0, 29'h0a5a5a5);
        repeat (8) @(negedge mclk);
        check("holdStrobe", strobes, rnd);
        holdReq = 1'h0;
        waitIdle();
        check("drained", addrQ.size() + rdQ.size() + wrQ.size(), 0);
        results();
    end

    // Hang guard, far above the few hundred cycles the run needs
    initial
    begin
        repeat (20000) @(posedge mclk);
        mismatches++;
        results();
    end
endmodule : cbs_bus_seq_tb_top
